// >>> shared/core_regs_pkg.sv
// Package: register map, field positions, reset values and carriers
// Summary of operation
// - ALU flag updates override a data write to Z, DC, C.
// - Software writes never change the time-out or power-down flags.
// - Clearing the status word gives 000u u1uu.
// - Bank select bit 5 picks the upper or lower half, resets to 0.
// - Time-out flag set by power-up, watchdog clear, sleep; cleared by time-out.
// - Carry and digit carry mean no borrow during subtraction.
// - Status and interrupt control words appear in both banks.
// - Interrupt flags set on events whatever the enables say; port change only on pins enabled in the pin mask.
// - A request to the core needs the global enable.
// - Peripheral sources also need the peripheral enable.
// - Interrupt control word holds five enables and three flags, resets 0.
// - Port change and external pin events set their flags.
// - Interrupt flags stay set until software clears them.
// - Peripheral enables at bits 7, 6, 3, 0, others read 0.
// - Peripheral flags share the enable positions and reset to 0.
// - Power-on flag at bit 1 cleared by power-on reset, set by software.
// - Brown-out flag at bit 0 cleared on brown-out until software sets it.
// - Reset-cause and status flags together tell the reset source apart.
// - Oscillator trim in bits 7:2, resets to centre code 100000.
// - Timer 0 runs unscaled when prescaler assign bit is set.
`default_nettype none
package core_regs_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_INTCTL = 8'h0B;
  localparam logic [7:0] ADDR_PFLAGS = 8'h0C;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_PENABLE = 8'h8C;
  localparam logic [7:0] ADDR_RCAUSE = 8'h8E;
  localparam logic [7:0] ADDR_TRIM = 8'h90;
  localparam logic [7:0] ADDR_PINMASK = 8'h96;
  localparam int C_BIT = 0;
  localparam int DC_BIT = 1;
  localparam int Z_BIT = 2;
  localparam int PD_BIT = 3;
  localparam int TO_BIT = 4;
  localparam int BANK_BIT = 5;
  localparam int PCF_BIT = 0;
  localparam int EXF_BIT = 1;
  localparam int T0F_BIT = 2;
  localparam int T0E_BIT = 5;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int GIE_BIT = 7;
  localparam int T1_BIT = 0;
  localparam int CM_BIT = 3;
  localparam int AD_BIT = 6;
  localparam int NV_BIT = 7;
  localparam int BOD_BIT = 0;
  localparam int POR_BIT = 1;
  localparam int PSA_BIT = 3;
  localparam int TRIM_LSB = 2;
  localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
  localparam logic [7:0] PERIPH_MASK = 8'hC9;
  localparam logic [7:0] RCAUSE_MASK = 8'h03;
  localparam logic [7:0] TRIM_MASK = 8'hFC;
  localparam logic [7:0] PINMASK_MASK = 8'h3F;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [7:0] PINMASK_RST = 8'h00;
  localparam logic [7:0] RCAUSE_POR = 8'h01;

  // ALU result and which flags the instruction touches
  typedef struct packed {
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic sub;
    logic carry;
    logic dcarry;
    logic [7:0] result;
  } alu_s;

  // One-cycle event pulses from core and peripherals
  typedef struct packed {
    logic t0_ovf;
    logic ext_pin;
    logic nv_done;
    logic conv_done;
    logic comp_change;
    logic t1_ovf;
    logic wdt_timeout;
    logic watchdog_clear_instr;
    logic sleep;
    logic brownout;
  } events_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] intctl;
    logic [7:0] pflags;
    logic [7:0] penable;
    logic [7:0] option;
    logic [7:0] rcause;
    logic [7:0] trim;
    logic [7:0] pinmask;
    logic [5:0] pin_sync1;
    logic [5:0] pin_sync2;
    logic [5:0] pin_ref;
    logic [7:0] rdata;
  } state_s;
endpackage
`default_nettype wire

// >>> hw/core_status_interrupt_regs.sv
// Core status, interrupt, reset-cause and trim register bank
//
// Design decision made here: strobed register access.
`default_nettype none
module core_status_interrupt_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic por_reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Core side
  input wire core_regs_pkg::alu_s alu,
  input wire core_regs_pkg::events_s ev,
  input wire logic [6:0] direct_offset,
  output logic [7:0] direct_data_addr,
  output logic irq_request,
  // Configuration outputs
  output logic bank_select_bit,
  output logic prescaler_assign_bit,
  output logic timer0_unscaled,
  output logic [5:0] osc_trim_code,
  // Port pins, asynchronous
  input wire logic [5:0] port_pins
);

  core_regs_pkg::state_s s;
  core_regs_pkg::state_s next_s;
  logic core_src;
  logic periph_src;
  logic [5:0] pin_diff;

  // Status and interrupt control are decoded in both banks
  function automatic logic hit_mirror(input logic [7:0] a,
                                      input logic [7:0] off);
    hit_mirror = (a[6:0] == off[6:0]);
  endfunction

  // Read mux; unmapped addresses and unused bits return 0
  function automatic logic [7:0] read_reg(input core_regs_pkg::state_s st,
                                          input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (hit_mirror(a, core_regs_pkg::ADDR_STATUS)) begin
      v = st.status;
    end else if (hit_mirror(a, core_regs_pkg::ADDR_INTCTL)) begin
      v = st.intctl;
    end else begin
      case (a)
        core_regs_pkg::ADDR_PFLAGS: v = st.pflags;
        core_regs_pkg::ADDR_PENABLE: v = st.penable;
        core_regs_pkg::ADDR_OPTION: v = st.option;
        core_regs_pkg::ADDR_RCAUSE: v = st.rcause;
        core_regs_pkg::ADDR_TRIM: v = st.trim;
        core_regs_pkg::ADDR_PINMASK: v = st.pinmask;
        default: v = 8'h00;
      endcase
    end
    read_reg = v;
  endfunction

  // Interrupt gating, all from registered state
  assign core_src = (s.intctl[core_regs_pkg::T0E_BIT]
                     & s.intctl[core_regs_pkg::T0F_BIT])
                  | |(s.intctl[4:3] & s.intctl[1:0]);
  assign periph_src = s.intctl[core_regs_pkg::PERIPHERAL_IRQ_ENABLE_BIT]
                    & |(s.penable & s.pflags);
  assign irq_request = s.intctl[core_regs_pkg::GIE_BIT]
                     & (core_src | periph_src);

  // Only the second synchroniser stage and its delayed copy are compared
  assign pin_diff = (s.pin_sync2 ^ s.pin_ref) & s.pinmask[5:0];

  // Outputs
  assign rdata = s.rdata;
  assign bank_select_bit = s.status[core_regs_pkg::BANK_BIT];
  assign direct_data_addr = {s.status[core_regs_pkg::BANK_BIT],
                             direct_offset};
  assign prescaler_assign_bit = s.option[core_regs_pkg::PSA_BIT];
  assign timer0_unscaled = s.option[core_regs_pkg::PSA_BIT];
  assign osc_trim_code = s.trim[7:core_regs_pkg::TRIM_LSB];

  // Next-state logic: write first, then hardware, so events win over clears
  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    next_s.pin_sync1 = port_pins;
    next_s.pin_sync2 = s.pin_sync1;
    next_s.pin_ref = s.pin_sync2;
    // Time-out and power-down are outside the write mask
    if (wr && hit_mirror(addr, core_regs_pkg::ADDR_STATUS)) begin
      next_s.status = (s.status & ~core_regs_pkg::STATUS_WR_MASK)
                    | (wdata & core_regs_pkg::STATUS_WR_MASK);
      // A flag-setting instruction blocks the write to all three ALU
      // flags, so a clear of status leaves carry and digit carry alone
      if (alu.upd_z || alu.upd_c || alu.upd_dc) begin
        next_s.status[2:0] = s.status[2:0];
      end
    end
    // ALU flags override the data write of the same instruction
    if (alu.upd_z) begin
      next_s.status[core_regs_pkg::Z_BIT] =
        (alu.result == 8'h00);
    end
    if (alu.upd_c) begin
      next_s.status[core_regs_pkg::C_BIT] =
        alu.carry ^ alu.sub;
    end
    if (alu.upd_dc) begin
      next_s.status[core_regs_pkg::DC_BIT] =
        alu.dcarry ^ alu.sub;
    end
    // Watchdog and sleep events; a time-out beats a same-cycle set
    if (ev.watchdog_clear_instr) begin
      next_s.status[core_regs_pkg::TO_BIT] = 1'b1;
      next_s.status[core_regs_pkg::PD_BIT] = 1'b1;
    end
    if (ev.sleep) begin
      next_s.status[core_regs_pkg::TO_BIT] = 1'b1;
      next_s.status[core_regs_pkg::PD_BIT] = 1'b0;
    end
    if (ev.wdt_timeout) begin
      next_s.status[core_regs_pkg::TO_BIT] = 1'b0;
    end
    // Interrupt control: stored as written, then events OR in
    if (wr && hit_mirror(addr, core_regs_pkg::ADDR_INTCTL)) begin
      next_s.intctl = wdata;
    end
    next_s.intctl[core_regs_pkg::T0F_BIT] =
      next_s.intctl[core_regs_pkg::T0F_BIT] | ev.t0_ovf;
    next_s.intctl[core_regs_pkg::EXF_BIT] =
      next_s.intctl[core_regs_pkg::EXF_BIT] | ev.ext_pin;
    next_s.intctl[core_regs_pkg::PCF_BIT] =
      next_s.intctl[core_regs_pkg::PCF_BIT] | (|pin_diff);
    // Peripheral flags share the enable layout
    if (wr && addr == core_regs_pkg::ADDR_PFLAGS) begin
      next_s.pflags = wdata & core_regs_pkg::PERIPH_MASK;
    end
    next_s.pflags[core_regs_pkg::NV_BIT] =
      next_s.pflags[core_regs_pkg::NV_BIT] | ev.nv_done;
    next_s.pflags[core_regs_pkg::AD_BIT] =
      next_s.pflags[core_regs_pkg::AD_BIT] | ev.conv_done;
    next_s.pflags[core_regs_pkg::CM_BIT] =
      next_s.pflags[core_regs_pkg::CM_BIT] | ev.comp_change;
    next_s.pflags[core_regs_pkg::T1_BIT] =
      next_s.pflags[core_regs_pkg::T1_BIT] | ev.t1_ovf;
    if (wr && addr == core_regs_pkg::ADDR_PENABLE) begin
      next_s.penable = wdata & core_regs_pkg::PERIPH_MASK;
    end
    if (wr && addr == core_regs_pkg::ADDR_OPTION) begin
      next_s.option = wdata;
    end
    if (wr && addr == core_regs_pkg::ADDR_TRIM) begin
      next_s.trim = wdata & core_regs_pkg::TRIM_MASK;
    end
    if (wr && addr == core_regs_pkg::ADDR_PINMASK) begin
      next_s.pinmask = wdata & core_regs_pkg::PINMASK_MASK;
    end
    // Reset cause: software sets, brown-out clears and wins
    if (wr && addr == core_regs_pkg::ADDR_RCAUSE) begin
      next_s.rcause = wdata & core_regs_pkg::RCAUSE_MASK;
    end
    if (ev.brownout) begin
      next_s.rcause[core_regs_pkg::BOD_BIT] = 1'b0;
    end
    if (rd) begin
      next_s.rdata = read_reg(s, addr);
    end
    // Synchronous reset; only a power-on reset or a brown-out touches the cause flags,
    // so watchdog and external resets stay tellable apart
    if (rst) begin
      next_s.status = (s.status & 8'h18) | (core_regs_pkg::STATUS_RST
                      & ~8'h18);
      next_s.intctl = core_regs_pkg::INTCTL_RST;
      next_s.pflags = core_regs_pkg::PERIPH_RST;
      next_s.penable = core_regs_pkg::PERIPH_RST;
      next_s.option = core_regs_pkg::OPTION_RST;
      next_s.trim = core_regs_pkg::TRIM_RST;
      next_s.pinmask = core_regs_pkg::PINMASK_RST;
      next_s.pin_ref = s.pin_sync2;
      next_s.rdata = 8'h00;
      if (por_reset) begin
        next_s.status[4:3] = core_regs_pkg::STATUS_RST[4:3];
        next_s.rcause = core_regs_pkg::RCAUSE_POR;
      end
      if (ev.brownout) begin
        next_s.rcause[core_regs_pkg::BOD_BIT] = 1'b0;
      end
    end
  end

  // Single state register
  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Helper: whether a status write stayed clear of flag events
  logic quiet_wr;
  assign quiet_wr = wr && hit_mirror(addr, core_regs_pkg::ADDR_STATUS)
                  && !ev.watchdog_clear_instr && !ev.sleep && !ev.wdt_timeout;

  zero_flag_a: assert property (alu.upd_z |=>
    s.status[core_regs_pkg::Z_BIT] == ($past(alu.result) == 8'h00))
    else $error("zero flag does not follow ALU result");

  flag_override_a: assert property (wr && alu.upd_c
    && hit_mirror(addr, core_regs_pkg::ADDR_STATUS) |=>
    s.status[core_regs_pkg::C_BIT] == ($past(alu.carry) ^ $past(alu.sub)))
    else $error("data write reached carry flag");

  to_pd_locked_a: assert property (quiet_wr |=>
    s.status[4:3] == $past(s.status[4:3]))
    else $error("software changed time-out or power-down flag");

  wdt_clears_a: assert property (ev.wdt_timeout |=>
    !s.status[core_regs_pkg::TO_BIT])
    else $error("time-out flag not cleared on watchdog time-out");

  sleep_flags_a: assert property (ev.sleep && !ev.wdt_timeout |=>
    s.status[core_regs_pkg::TO_BIT] && !s.status[core_regs_pkg::PD_BIT])
    else $error("sleep flags wrong");

  borrow_sense_a: assert property (alu.upd_dc && alu.sub |=>
    s.status[core_regs_pkg::DC_BIT] == !$past(alu.dcarry))
    else $error("digit borrow polarity wrong");

  flag_sticky_a: assert property (
    s.intctl[core_regs_pkg::T0F_BIT]
    && !(wr && hit_mirror(addr, core_regs_pkg::ADDR_INTCTL))
    |=> s.intctl[core_regs_pkg::T0F_BIT])
    else $error("timer flag dropped without software clear");

  flag_sets_a: assert property (ev.comp_change |=>
    s.pflags[core_regs_pkg::CM_BIT])
    else $error("comparator flag not set");

  irq_global_a: assert property (irq_request |->
    s.intctl[core_regs_pkg::GIE_BIT])
    else $error("request without global enable");

  periph_gate_a: assert property (irq_request && !core_src |->
    s.intctl[core_regs_pkg::PERIPHERAL_IRQ_ENABLE_BIT])
    else $error("peripheral request without peripheral enable");

  brownout_clr_a: assert property (ev.brownout |=>
    !s.rcause[core_regs_pkg::BOD_BIT] ##1 1)
    else $error("brown-out flag not cleared");

  unused_zero_a: assert property (rd
    && addr == core_regs_pkg::ADDR_RCAUSE |=> rdata[7:2] == 6'h00
    ##1 rdata == 8'h00 || $past(rd))
    else $error("unimplemented bits read nonzero");

  bank_route_a: assert property (
    direct_data_addr[7] == s.status[core_regs_pkg::BANK_BIT])
    else $error("direct address ignores bank select");

  // Register-level checks on flag updates, gating and unused bits
  clear_status_a: assert property (
    quiet_wr && wdata == 8'h00 && alu.upd_z && !alu.upd_c && !alu.upd_dc
    && alu.result == 8'h00 |=> s.status[7:5] == 3'b000 && s.status[2]
    && s.status[4:0] == ($past(s.status[4:0]) | 5'h04))
    else $error("status clear pattern wrong");

  alu_block_a: assert property (
    wr && hit_mirror(addr, core_regs_pkg::ADDR_STATUS) && alu.upd_z
    && !alu.upd_dc |=> s.status[core_regs_pkg::DC_BIT]
    == $past(s.status[core_regs_pkg::DC_BIT]))
    else $error("data write reached digit carry flag");

  status_store_a: assert property (quiet_wr |=>
    s.status[7:5] == $past(wdata[7:5]))
    else $error("status upper bits not stored");

  watchdog_clear_instr_flags_a: assert property (
    ev.watchdog_clear_instr && !ev.sleep && !ev.wdt_timeout |=>
    s.status[core_regs_pkg::TO_BIT] && s.status[core_regs_pkg::PD_BIT])
    else $error("watchdog clear did not set flags");

  rd_mirror_a: assert property (
    rd && hit_mirror(addr, core_regs_pkg::ADDR_STATUS) |=>
    rdata == $past(s.status))
    else $error("status read wrong in a bank");

  t0_flag_a: assert property (ev.t0_ovf |=>
    s.intctl[core_regs_pkg::T0F_BIT])
    else $error("timer flag not set");

  irq_t0_a: assert property (
    s.intctl[core_regs_pkg::GIE_BIT] && s.intctl[core_regs_pkg::T0E_BIT]
    && s.intctl[core_regs_pkg::T0F_BIT] |-> irq_request)
    else $error("enabled timer flag gave no request");

  irq_periph_a: assert property (
    s.intctl[core_regs_pkg::GIE_BIT] && s.intctl[core_regs_pkg::PERIPHERAL_IRQ_ENABLE_BIT]
    && |(s.penable & s.pflags) |-> irq_request)
    else $error("enabled peripheral flag gave no request");

  intctl_write_a: assert property (
    wr && hit_mirror(addr, core_regs_pkg::ADDR_INTCTL) && ev == '0
    && pin_diff == 6'h00 |=> s.intctl == $past(wdata))
    else $error("interrupt control write not stored");

  ext_flag_a: assert property (ev.ext_pin |=>
    s.intctl[core_regs_pkg::EXF_BIT])
    else $error("external pin flag not set");

  port_flag_a: assert property (|pin_diff |=>
    s.intctl[core_regs_pkg::PCF_BIT])
    else $error("port change flag not set");

  t1_sticky_a: assert property (
    s.pflags[core_regs_pkg::T1_BIT]
    && !(wr && addr == core_regs_pkg::ADDR_PFLAGS)
    |=> s.pflags[core_regs_pkg::T1_BIT])
    else $error("timer 1 flag dropped without software clear");

  penable_gaps_a: assert property (
    (s.penable & ~core_regs_pkg::PERIPH_MASK) == 8'h00)
    else $error("unused enable bit set");

  pflags_gaps_a: assert property (
    (s.pflags & ~core_regs_pkg::PERIPH_MASK) == 8'h00)
    else $error("unused flag bit set");

  rcause_gaps_a: assert property (
    s.rcause[7:2] == 6'h00)
    else $error("unused reset cause bit set");

  bod_sticky_a: assert property (
    !s.rcause[core_regs_pkg::BOD_BIT]
    && !(wr && addr == core_regs_pkg::ADDR_RCAUSE)
    |=> !s.rcause[core_regs_pkg::BOD_BIT])
    else $error("brown-out flag set without software");

  trim_gaps_a: assert property (
    s.trim[1:0] == 2'b00)
    else $error("unused trim bit set");

  option_store_a: assert property (
    wr && addr == core_regs_pkg::ADDR_OPTION |=>
    timer0_unscaled == $past(wdata[core_regs_pkg::PSA_BIT]))
    else $error("unscaled output ignores option write");

  irq_seen_c: cover property (irq_request && periph_src);
  clr_status_c: cover property (quiet_wr && wdata == 8'h00 && alu.upd_z);
  pin_change_c: cover property (|pin_diff ##1
    s.intctl[core_regs_pkg::PCF_BIT]);
  sleep_wake_c: cover property (ev.sleep ##[1:20] ev.wdt_timeout);

endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the core status and interrupt register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, por_reset, wr, rd;
  logic [7:0] addr, wdata, rdata, direct_data_addr;
  core_regs_pkg::alu_s alu;
  core_regs_pkg::events_s ev;
  logic [6:0] direct_offset;
  logic irq_request, bank_select_bit, prescaler_assign_bit, timer0_unscaled;
  logic [5:0] osc_trim_code, port_pins;
  int miscompares = 0;
  int cmp_count = 0;

  core_status_interrupt_regs dut (.mclk(mclk), .rst(rst),
    .por_reset(por_reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .alu(alu), .ev(ev), .direct_offset(direct_offset),
    .direct_data_addr(direct_data_addr), .irq_request(irq_request),
    .bank_select_bit(bank_select_bit),
    .prescaler_assign_bit(prescaler_assign_bit),
    .timer0_unscaled(timer0_unscaled), .osc_trim_code(osc_trim_code),
    .port_pins(port_pins));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One bus cycle, optionally with an ALU flag update in the same cycle
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [13:0] al);
    @(posedge mclk);
    wr <= w;
    addr <= a;
    wdata <= d;
    alu <= al;
    @(posedge mclk);
    wr <= 1'b0;
    alu <= '0;
    #1;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, a, d, 14'h0000);
  endtask

  // Read is checked in the single cycle where the data stands
  task automatic rchk(input string name, input logic [7:0] a,
                      input logic [7:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask

  task automatic pulse(input logic [9:0] e);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= '0;
    #1;
  endtask

  task automatic do_reset(input logic por, input logic bo);
    @(posedge mclk);
    rst <= 1'b1;
    por_reset <= por;
    ev <= {9'h000, bo};
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    por_reset <= 1'b0;
    ev <= '0;
  endtask

  task automatic t_reset_vals();
    logic [7:0] ad[8] = '{8'h03, 8'h0B, 8'h0C, 8'h8C, 8'h8E, 8'h90, 8'h81,
                          8'h0D};
    logic [7:0] ex[8] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'h01, 8'h80, 8'hFF,
                          8'h00};
    for (int i = 0; i < 8; i++) begin
      rchk("reset value", ad[i], ex[i]);
    end
    chk("trim out", {2'b00, osc_trim_code}, 8'h20);
  endtask

  task automatic t_status();
    // Move from W; reserved bits kept clear, zeros aimed at TO and PD
    wreg(8'h03, 8'h27);
    rchk("status mirror", 8'h83, 8'h3F);
    chk("bank bit", {7'h00, bank_select_bit}, 8'h01);
    chk("direct addr", direct_data_addr, 8'h95);
    // Clear of the status word while the zero flag is being updated
    cyc(1'b1, 8'h03, 8'h00, {6'b100000, 8'h00});
    rchk("status clear", 8'h03, 8'h1F);
    chk("direct low", direct_data_addr, 8'h15);
  endtask

  task automatic t_alu();
    // Subtraction with borrow out of bit 7, none out of the low nibble
    cyc(1'b0, 8'h00, 8'h00, {6'b111110, 8'h05});
    rchk("sub flags", 8'h03, 8'h1A);
    cyc(1'b0, 8'h00, 8'h00, {6'b111010, 8'h00});
    rchk("add flags", 8'h03, 8'h1D);
  endtask

  task automatic t_power();
    pulse(10'h002);
    rchk("after sleep", 8'h03, 8'h15);
    pulse(10'h008);
    rchk("after timeout", 8'h03, 8'h05);
    pulse(10'h004);
    rchk("after clear", 8'h03, 8'h1D);
  endtask

  task automatic t_irq();
    pulse(10'h200);
    rchk("t0 flag", 8'h0B, 8'h04);
    chk("irq masked", {7'h00, irq_request}, 8'h00);
    wreg(8'h0B, 8'hA4);
    chk("irq t0", {7'h00, irq_request}, 8'h01);
    rchk("t0 sticky", 8'h8B, 8'hA4);
    wreg(8'h0B, 8'hA0);
    chk("irq cleared", {7'h00, irq_request}, 8'h00);
    pulse(10'h100);
    rchk("ext flag", 8'h0B, 8'hA2);
    wreg(8'h0B, 8'h80);
    pulse(10'h010);
    wreg(8'h8C, 8'h01);
    chk("irq no peripheral_irq_enable", {7'h00, irq_request}, 8'h00);
    wreg(8'h0B, 8'hC0);
    chk("irq peripheral_irq_enable", {7'h00, irq_request}, 8'h01);
    rchk("t1 flag", 8'h0C, 8'h01);
    wreg(8'h0C, 8'h00);
    chk("irq t1 clr", {7'h00, irq_request}, 8'h00);
    wreg(8'h0B, 8'h00);
    // Pin change on an enabled pin, through the synchroniser
    wreg(8'h96, 8'h01);
    @(posedge mclk);
    port_pins <= 6'h01;
    repeat (6) @(posedge mclk);
    rchk("pin change", 8'h0B, 8'h01);
  endtask

  task automatic t_masks();
    logic [7:0] ad[4] = '{8'h8C, 8'h0C, 8'h8E, 8'h90};
    logic [7:0] ex[4] = '{8'hC9, 8'hC9, 8'h03, 8'hFC};
    for (int i = 0; i < 4; i++) begin
      wreg(ad[i], 8'hFF);
      rchk("masked bits", ad[i], ex[i]);
    end
    chk("trim max", {2'b00, osc_trim_code}, 8'h3F);
    chk("unscaled", {7'h00, timer0_unscaled}, 8'h01);
    wreg(8'h81, 8'h00);
    chk("scaled", {7'h00, timer0_unscaled}, 8'h00);
    chk("psa", {7'h00, prescaler_assign_bit}, 8'h00);
    wreg(8'h0C, 8'h00);
    wreg(8'h8C, 8'h00);
    // Write-done, conversion and comparator events together
    pulse(10'h0E0);
    rchk("periph flags", 8'h0C, 8'hC8);
    wreg(8'h0C, 8'h00);
  endtask

  task automatic t_resets();
    do_reset(1'b0, 1'b1);
    rchk("brownout cause", 8'h8E, 8'h02);
    pulse(10'h008);
    do_reset(1'b0, 1'b0);
    rchk("wdt reset status", 8'h03, 8'h08);
    rchk("cause kept", 8'h8E, 8'h02);
    // Brown-out in normal running clears the flag software had set
    wreg(8'h8E, 8'h03);
    pulse(10'h001);
    rchk("brownout live", 8'h8E, 8'h02);
  endtask

  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #(50 * 3000);
    miscompares++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    por_reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    alu = '0;
    ev = '0;
    direct_offset = 7'h15;
    port_pins = 6'h00;
    do_reset(1'b1, 1'b0);
    t_reset_vals();
    t_status();
    t_alu();
    t_power();
    t_irq();
    t_masks();
    t_resets();
    give_verdict();
  end
endmodule
`default_nettype wire
